// [arc_pkg.sv]
package arc_pkg;

    // bus geometry
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam int          RES_W         = 12;
    localparam int          PIN_N         = 8;

    // register byte offsets
    localparam logic [7:0]  OFF_RES_LOW   = 8'h00;
    localparam logic [7:0]  OFF_RES_HIGH  = 8'h04;
    localparam logic [7:0]  OFF_CTRL_A    = 8'h08;
    localparam logic [7:0]  OFF_CTRL_B    = 8'h0C;
    localparam logic [7:0]  OFF_PIN_SEL   = 8'h10;

    // converter_control_a fields
    localparam int          CA_START      = 7;
    localparam int          CA_BUSY       = 6;
    localparam int          CA_ENABLE     = 5;
    localparam int          CA_ALIGN      = 4;
    localparam int          CA_CH_LSB     = 0;
    localparam int          CA_CH_W       = 4;

    // converter_control_b fields
    localparam int          CB_SRC_LSB    = 5;
    localparam int          CB_SRC_W      = 3;
    localparam int          CB_REF_LSB    = 3;
    localparam int          CB_REF_W      = 2;
    localparam int          CB_CLK_LSB    = 0;
    localparam int          CB_CLK_W      = 3;

    // input source code that selects the external channel
    localparam logic [2:0]  SRC_EXTERNAL  = 3'h0;

    // values after reset
    localparam logic [7:0]  CTRL_A_RST    = 8'h00;
    localparam logic [7:0]  CTRL_B_RST    = 8'h00;
    localparam logic [7:0]  PIN_SEL_RST   = 8'h00;
    localparam logic [11:0] RES_RST       = 12'h000;

endpackage : arc_pkg

// [arc_pin_ctl.sv]
`timescale 1ns/1ps
`default_nettype none

module arc_pin_ctl
    import arc_pkg::*;
(
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // configuration
    input  wire logic [PIN_N-1:0] analog_sel,
    input  wire logic [PIN_N-1:0] pullup_cfg,
    // pin control
    output logic      [PIN_N-1:0] digital_en_r,
    output logic      [PIN_N-1:0] pullup_en_r,
    output logic      [PIN_N-1:0] analog_conn_r
);

    genvar g;
    generate
        for (g = 0; g < PIN_N; g = g + 1) begin : g_pin
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    digital_en_r[g]  <= 1'b1;
                    pullup_en_r[g]   <= 1'b0;
                    analog_conn_r[g] <= 1'b0;
                end else begin
                    // analog use drops the digital and shared functions
                    digital_en_r[g]  <= ~analog_sel[g];
                    // pull-high forced off whatever its own setting says
                    pullup_en_r[g]   <= pullup_cfg[g] & ~analog_sel[g];
                    analog_conn_r[g] <= analog_sel[g];
                end
            end
        end
    endgenerate

endmodule : arc_pin_ctl

`default_nettype wire

// [arc_regs.sv]
// How it works
// - result shown in two read-only bytes
// - alignment bit picks left or right format
// - bytes without result bits read zero
// - disabled converter keeps stored result
// - completed conversion becomes readable result
// - two 8-bit control registers hold fields
// - one analog source reaches converter while enabled, none while disabled
// - channel field picks the external pin
// - source field picks internal or external
// - analog pins lose digital and shared functions
// - analog pins lose their pull-high resistor
`timescale 1ns/1ps
`default_nettype none

module arc_regs
    import arc_pkg::*;
(
    // apb clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    // conversion core
    input  wire logic              conv_done,
    input  wire logic [RES_W-1:0]  conv_data,
    output logic                   conv_start,
    output logic                   conv_enable,
    output logic      [CB_REF_W-1:0] ref_sel,
    output logic      [CB_CLK_W-1:0] clk_sel,
    // input multiplexer
    output logic                   mux_ext_en,
    output logic      [CA_CH_W-1:0] mux_ext_ch,
    output logic                   mux_int_en,
    output logic      [CB_SRC_W-1:0] mux_int_sel,
    // shared pins
    input  wire logic [PIN_N-1:0]  pullup_cfg,
    output logic      [PIN_N-1:0]  pin_digital_en,
    output logic      [PIN_N-1:0]  pin_pullup_en,
    output logic      [PIN_N-1:0]  pin_analog_conn
);

    logic [7:0]        ctrl_a_r;
    logic [7:0]        ctrl_b_r;
    logic [7:0]        pin_sel_r;
    logic [RES_W-1:0]  result_r;
    logic              busy_r;
    logic              start_r;
    logic [DATA_W-1:0] prdata_r;
    logic [DATA_W-1:0] prdata_nxt;
    logic              pready_r;
    logic              pslverr_r;
    logic              slverr_nxt;
    logic              conv_start_r;
    logic              mux_ext_en_r;
    logic [CA_CH_W-1:0] mux_ext_ch_r;
    logic              mux_int_en_r;
    logic [CB_SRC_W-1:0] mux_int_sel_r;
    logic              setup;
    logic              wr_take;
    logic              align;
    logic              enable;
    logic [7:0]        res_low;
    logic [7:0]        res_high;
    logic [2:0]        src;

    // a transfer is decoded at the setup edge; the access phase then
    // completes in one cycle with pready high, and a write lands only
    // at that completing edge
    assign setup   = psel & ~penable;
    assign wr_take = psel & penable & pready_r & pwrite & pstrb[0];
    assign align   = ctrl_a_r[CA_ALIGN];
    assign enable  = ctrl_a_r[CA_ENABLE];
    assign src     = ctrl_b_r[CB_SRC_LSB +: CB_SRC_W];

    // result byte views, unused bits forced low
    always_comb begin
        if (align) begin
            res_low  = result_r[7:0];
            res_high = {4'h0, result_r[11:8]};
        end else begin
            res_low  = {result_r[3:0], 4'h0};
            res_high = result_r[11:4];
        end
    end

    // read mux and unmapped-address decode
    always_comb begin
        prdata_nxt = '0;
        slverr_nxt = 1'b0;
        case (paddr)
            OFF_RES_LOW: begin
                prdata_nxt[7:0] = res_low;
                slverr_nxt      = pwrite;
            end
            OFF_RES_HIGH: begin
                prdata_nxt[7:0] = res_high;
                slverr_nxt      = pwrite;
            end
            OFF_CTRL_A: begin
                prdata_nxt[7:0] = {start_r, busy_r, ctrl_a_r[5:0]};
            end
            OFF_CTRL_B: begin
                prdata_nxt[7:0] = ctrl_b_r;
            end
            OFF_PIN_SEL: begin
                prdata_nxt[7:0] = pin_sel_r;
            end
            default: begin
                slverr_nxt = 1'b1;
            end
        endcase
    end

    // apb answer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= '0;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= setup;
            pslverr_r <= setup & slverr_nxt;
            if (setup && !pwrite) begin
                prdata_r <= prdata_nxt;
            end else if (!psel) begin
                prdata_r <= '0;
            end
        end
    end

    // control register a: enable, align and channel; start and busy
    // are handled apart
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_a_r <= CTRL_A_RST;
        end else if (wr_take && paddr == OFF_CTRL_A) begin
            ctrl_a_r[5:0] <= pwdata[5:0];
            ctrl_a_r[7:6] <= 2'b00;
        end
    end

    // control register b: source, reference and clock selects
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_b_r <= CTRL_B_RST;
        end else if (wr_take && paddr == OFF_CTRL_B) begin
            ctrl_b_r <= pwdata[7:0];
        end
    end

    // which shared pins serve as converter inputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_sel_r <= PIN_SEL_RST;
        end else if (wr_take && paddr == OFF_PIN_SEL) begin
            pin_sel_r <= pwdata[7:0];
        end
    end

    // start bit holds the written value; a low-to-high write that also
    // sets enable launches one conversion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_r      <= 1'b0;
            conv_start_r <= 1'b0;
        end else begin
            conv_start_r <= 1'b0;
            if (wr_take && paddr == OFF_CTRL_A) begin
                start_r <= pwdata[CA_START];
                if (pwdata[CA_START] && !start_r && pwdata[CA_ENABLE]) begin
                    conv_start_r <= 1'b1;
                end
            end
        end
    end

    // busy from launch until done or until enable drops; a new launch in the done cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_r <= 1'b0;
        end else if (conv_start_r) begin
            busy_r <= 1'b1;
        end else if (conv_done || !enable) begin
            busy_r <= 1'b0;
        end
    end

    // whole 12-bit word captured at once so both bytes match; a
    // disabled converter leaves the stored value alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_r <= RES_RST;
        end else if (conv_done && enable) begin
            result_r <= conv_data;
        end
    end

    // input routing: only one of external or internal is ever on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mux_ext_en_r  <= 1'b0;
            mux_int_en_r  <= 1'b0;
            mux_ext_ch_r  <= '0;
            mux_int_sel_r <= '0;
        end else begin
            mux_ext_en_r  <= enable && (src == SRC_EXTERNAL);
            mux_int_en_r  <= enable && (src != SRC_EXTERNAL);
            mux_ext_ch_r  <= ctrl_a_r[CA_CH_LSB +: CA_CH_W];
            mux_int_sel_r <= src;
        end
    end

    // shared-pin function and pull-high control
    arc_pin_ctl u_pin_ctl (
        .pclk          (pclk),
        .presetn       (presetn),
        .analog_sel    (pin_sel_r),
        .pullup_cfg    (pullup_cfg),
        .digital_en_r  (pin_digital_en),
        .pullup_en_r   (pin_pullup_en),
        .analog_conn_r (pin_analog_conn)
    );

    assign prdata      = prdata_r;
    assign pready      = pready_r;
    assign pslverr     = pslverr_r;
    assign conv_start  = conv_start_r;
    assign conv_enable = ctrl_a_r[CA_ENABLE];
    assign ref_sel     = ctrl_b_r[CB_REF_LSB +: CB_REF_W];
    assign clk_sel     = ctrl_b_r[CB_CLK_LSB +: CB_CLK_W];
    assign mux_ext_en  = mux_ext_en_r;
    assign mux_ext_ch  = mux_ext_ch_r;
    assign mux_int_en  = mux_int_en_r;
    assign mux_int_sel = mux_int_sel_r;

endmodule : arc_regs

`default_nettype wire

// [arc_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module arc_core_model
    import arc_pkg::*;
(
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // from the block
    input  wire logic             conv_start,
    input  wire logic             conv_enable,
    // bench control
    input  wire logic [RES_W-1:0] sample,
    input  wire logic             stray,
    // to the block
    output logic                  conv_done,
    output logic      [RES_W-1:0] conv_data
);
    logic [3:0] cnt_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 4'h0;
        end else if (conv_start) begin
            cnt_r <= 4'h6;
        end else if (!conv_enable) begin
            cnt_r <= 4'h0;
        end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
        end
    end
    assign conv_done = (cnt_r == 4'h1) || stray;
    // data is valid only with done; scrambled otherwise
    assign conv_data = conv_done ? sample : ~sample;
endmodule : arc_core_model
`default_nettype wire

// [arc_regs_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module arc_regs_checker
    import arc_pkg::*;
(
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    input  wire logic [DATA_W-1:0] prdata,
    input  wire logic              pready,
    input  wire logic              pslverr,
    // core, mux and pins
    input  wire logic              conv_start,
    input  wire logic              conv_enable,
    input  wire logic              mux_ext_en,
    input  wire logic              mux_int_en,
    input  wire logic [PIN_N-1:0]  pullup_cfg,
    input  wire logic [PIN_N-1:0]  pin_digital_en,
    input  wire logic [PIN_N-1:0]  pin_pullup_en,
    input  wire logic [PIN_N-1:0]  pin_analog_conn
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready is not a one cycle answer");
    chk_result_ro: assert property (psel && !penable && pwrite && paddr <= OFF_RES_HIGH
        |=> pready && pslverr) else $error("result write not refused");
    chk_upper_zero: assert property (prdata[31:8] == 24'h0)
        else $error("read data above the byte lane");
    chk_start_cause: assert property (conv_start |-> $past(psel && penable && pwrite
        && paddr == OFF_CTRL_A && pwdata[CA_START] && pwdata[CA_ENABLE]))
        else $error("start pulse without enabled start write");
    chk_one_source: assert property (!(mux_ext_en && mux_int_en))
        else $error("two sources routed");
    chk_off_no_route: assert property (!conv_enable && !$past(conv_enable)
        |-> !mux_ext_en && !mux_int_en) else $error("source routed while disabled");
    chk_pin_digital: assert property (pin_digital_en == ~pin_analog_conn)
        else $error("analog pin keeps digital function");
    chk_pullup_off: assert property ($past(presetn) |->
        pin_pullup_en == ($past(pullup_cfg) & ~pin_analog_conn))
        else $error("pull-high wrong on shared pin");
endmodule : arc_regs_checker
bind arc_regs arc_regs_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_start(conv_start), .conv_enable(conv_enable),
    .mux_ext_en(mux_ext_en), .mux_int_en(mux_int_en), .pullup_cfg(pullup_cfg),
    .pin_digital_en(pin_digital_en), .pin_pullup_en(pin_pullup_en),
    .pin_analog_conn(pin_analog_conn));
`default_nettype wire

// [arc_regs_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module arc_regs_bench;
    import arc_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
    logic [7:0] paddr = 8'h00, pullup_cfg = 8'h00, pde, ppe, pac;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hF, ext_ch;
    logic conv_done, conv_start, conv_enable, stray = 0, ext_en, int_en;
    logic [11:0] conv_data, sample = 12'h000;
    logic [1:0] ref_sel;
    logic [2:0] clk_sel, int_sel;
    int err_total = 0, tests_run = 0, cyc = 0, n;
    // align, data, expected high, expected low
    localparam logic [28:0] ROWS [4] = '{{1'b0, 12'hABC, 8'hAB, 8'hC0},
        {1'b1, 12'hABC, 8'h0A, 8'hBC}, {1'b1, 12'hFFF, 8'h0F, 8'hFF},
        {1'b0, 12'h001, 8'h00, 8'h10}};
    always #4 pclk = ~pclk;
    arc_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .conv_done(conv_done), .conv_data(conv_data),
        .conv_start(conv_start), .conv_enable(conv_enable), .ref_sel(ref_sel),
        .clk_sel(clk_sel), .mux_ext_en(ext_en), .mux_ext_ch(ext_ch), .mux_int_en(int_en),
        .mux_int_sel(int_sel), .pullup_cfg(pullup_cfg), .pin_digital_en(pde),
        .pin_pullup_en(ppe), .pin_analog_conn(pac));
    arc_core_model core_u (.pclk(pclk), .presetn(presetn), .conv_start(conv_start),
        .conv_enable(conv_enable), .sample(sample), .stray(stray), .conv_done(conv_done),
        .conv_data(conv_data));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            test_done;
        end
    end
    initial begin
        repeat (2) @(posedge pclk);
        chk(pde, 8'hFF);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            apb(0, 8'(i * 4), 0);
            chk(rd, 0);
        end
        $display("reset values done");
        foreach (ROWS[i]) begin
            sample <= ROWS[i][27:16];
            apb(1, OFF_CTRL_A, {24'h0, 3'b001, ROWS[i][28], 4'h3});
            apb(1, OFF_CTRL_A, {24'h0, 3'b101, ROWS[i][28], 4'h3});
            apb(0, OFF_CTRL_A, 0);
            chk(rd[CA_BUSY], 1);
            for (n = 0; n < 20 && conv_done !== 1'b1; n++) @(posedge pclk);
            apb(0, OFF_RES_LOW, 0);
            chk(rd, ROWS[i][7:0]);
            apb(0, OFF_RES_HIGH, 0);
            chk(rd, ROWS[i][15:8]);
            apb(0, OFF_CTRL_A, 0);
            chk(rd, {24'h0, 3'b101, ROWS[i][28], 4'h3});
        end
        $display("conversion rows done");
        apb(1, OFF_RES_LOW, 32'hFF);
        chk(er, 1);
        apb(0, 8'h14, 0);
        chk({er, rd}, {1'b1, 32'h0});
        apb(1, OFF_CTRL_A, 0);
        sample <= 12'h555;
        stray <= 1'b1;
        @(posedge pclk);
        stray <= 1'b0;
        apb(0, OFF_RES_LOW, 0);
        chk(rd, 8'h10);
        $display("refusal and disabled hold done");
        apb(1, OFF_CTRL_B, 8'h75);
        pstrb <= 4'h0;
        apb(1, OFF_CTRL_B, 8'hFF);
        pstrb <= 4'hF;
        apb(0, OFF_CTRL_B, 0);
        chk({rd, ref_sel, clk_sel}, {32'h75, 2'h2, 3'h5});
        apb(1, OFF_CTRL_A, 8'h27);
        repeat (2) @(posedge pclk);
        chk({int_en, ext_en, int_sel}, {2'b10, 3'h3});
        apb(1, OFF_CTRL_B, 8'h15);
        repeat (2) @(posedge pclk);
        chk({int_en, ext_en, ext_ch}, {2'b01, 4'h7});
        pullup_cfg <= 8'hFF;
        apb(1, OFF_PIN_SEL, 8'hA5);
        repeat (2) @(posedge pclk);
        chk({pde, ppe, pac}, 24'h5A5AA5);
        $display("routing and pins done");
        test_done;
    end
endmodule : arc_regs_bench
`default_nettype wire
